// *** src/sample_ctrl_pkg.sv ***
package sample_ctrl_pkg;

   // =========================================================
   // register indices (byte address is four times the index)
   // =========================================================
   localparam logic [3:0] idx_a_div = 4'h1;
   localparam logic [3:0] idx_b_div = 4'h2;
   localparam logic [3:0] idx_trim = 4'h3;
   localparam logic [3:0] idx_gain = 4'h4;
   localparam logic [3:0] idx_input = 4'h5;
   localparam logic [3:0] idx_mode = 4'h6;
   localparam logic [3:0] idx_ctrl_word = 4'h9;
   localparam logic [3:0] idx_status = 4'ha;

   // =========================================================
   // field positions
   // =========================================================
   localparam int gain_lsb = 2;
   localparam int mode_force_sec = 2;
   localparam int mode_sixteen = 3;
   localparam int mode_free_run = 5;
   localparam int cw_primary_lsb = 0;
   localparam int cw_secondary_lsb = 2;
   localparam int cw_is_secondary = 4;
   localparam int st_sec_req = 0;
   localparam int st_earlier = 1;
   localparam int st_later = 2;
   localparam int st_comp_err = 3;
   localparam int st_latch_pend = 4;
   localparam int st_xfer = 5;

   // =========================================================
   // reset values and codes
   // =========================================================
   localparam logic [7:0] a_div_reset = 8'h12;
   localparam logic [7:0] b_div_reset = 8'h0f;
   localparam logic [7:0] trim_reset = 8'h00;
   localparam logic [7:0] gain_reset = 8'h00;
   localparam logic [7:0] input_reset = 8'h01;
   localparam logic [7:0] mode_reset = 8'h00;
   localparam logic [7:0] comp_tuned_b = 8'h0f;
   localparam logic [1:0] ctrl_none = 2'b00;
   localparam logic [1:0] ctrl_increase = 2'b01;
   localparam logic [1:0] ctrl_decrease = 2'b10;
   localparam logic [1:0] ctrl_both = 2'b11;
   localparam logic [1:0] sel_loopback = 2'b00;
   localparam logic [1:0] sel_summing = 2'b11;
   localparam logic [4:0] shift_bits = 5'h10;
   localparam logic [7:0] period_mult = 8'h02;

endpackage : sample_ctrl_pkg

// *** src/sample_period_ctrl.sv ***
// Implementation choices: the register offsets and the APB interface to the registers.
module sample_period_ctrl #(
   parameter int div_width = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hw_request_hi,
   input wire logic hw_request_lo,
   input wire logic frame_sync_n,
   input wire logic shift_clock,
   input wire logic [15:0] adc_result,
   output logic frame_start,
   output logic filter_clock,
   output logic secondary_request,
   output logic adjust_earlier,
   output logic adjust_later,
   output logic loopback_en,
   output logic summing_en,
   output logic [1:0] input_gain,
   output logic [15:0] result_word,
   output logic result_valid
);

   // =========================================================
   // request decoding
   // =========================================================
   // returns {secondary request, earlier, later}
   function automatic logic [2:0] decode_req(input logic [1:0] sw, input logic [1:0] hw,
                                             input logic in_secondary);
      logic [2:0] r;
      r = 3'b000;
      if (!in_secondary) begin
         if (sw == sample_ctrl_pkg::ctrl_increase) begin
            r[0] = 1'b1;
         end else if (sw == sample_ctrl_pkg::ctrl_decrease) begin
            r[1] = 1'b1;
         end else if (hw == sample_ctrl_pkg::ctrl_increase) begin
            r[0] = 1'b1;
         end else if (hw == sample_ctrl_pkg::ctrl_decrease) begin
            r[1] = 1'b1;
         end
         r[2] = (sw == sample_ctrl_pkg::ctrl_both) || (hw == sample_ctrl_pkg::ctrl_both);
      end else begin
         // pins only count while the secondary bits are 11
         if (sw == sample_ctrl_pkg::ctrl_increase) begin
            r[0] = 1'b1;
         end else if (sw == sample_ctrl_pkg::ctrl_decrease) begin
            r[1] = 1'b1;
         end else if (sw == sample_ctrl_pkg::ctrl_both) begin
            r[0] = (hw == sample_ctrl_pkg::ctrl_increase);
            r[1] = (hw == sample_ctrl_pkg::ctrl_decrease);
         end
      end
      return r;
   endfunction : decode_req

   // length of the first A-counter cycle, never below one clock
   function automatic logic [div_width+1:0] first_len(input logic [div_width-1:0] a,
                                                      input logic [7:0] trim,
                                                      input logic later, input logic earlier);
      logic signed [div_width+2:0] v;
      logic signed [div_width+2:0] t;
      v = $signed({3'b000, a});
      t = (div_width + 3)'($signed(trim));
      if (later) begin
         v = v + t;
      end else if (earlier) begin
         v = v - t;
      end
      if (v < 1) begin
         v = (div_width + 3)'(1);
      end
      return v[div_width+1:0];
   endfunction : first_len

   // =========================================================
   // synchronisers for pins
   // =========================================================
   logic [1:0] hw_s1;
   logic [1:0] hw_s2;
   logic fs_s1;
   logic fs_s2;
   logic fs_s3;
   logic sc_s1;
   logic sc_s2;
   logic sc_s3;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hw_s1 <= 2'b00;
         hw_s2 <= 2'b00;
         fs_s1 <= 1'b1;
         fs_s2 <= 1'b1;
         fs_s3 <= 1'b1;
         sc_s1 <= 1'b0;
         sc_s2 <= 1'b0;
         sc_s3 <= 1'b0;
      end else begin
         hw_s1 <= {hw_request_hi, hw_request_lo};
         hw_s2 <= hw_s1;
         fs_s1 <= frame_sync_n;
         fs_s2 <= fs_s1;
         fs_s3 <= fs_s2;
         sc_s1 <= shift_clock;
         sc_s2 <= sc_s1;
         sc_s3 <= sc_s2;
      end
   end

   wire fs_fall = fs_s3 && !fs_s2;
   wire sc_rise = sc_s2 && !sc_s3;

   // =========================================================
   // register file over apb
   // =========================================================
   logic [div_width-1:0] a_div;
   logic [div_width-1:0] b_div;
   logic [7:0] trim;
   logic [7:0] gain_reg;
   logic [7:0] input_reg;
   logic [7:0] mode_reg;
   logic [4:0] ctrl_word;
   logic [5:0] status;

   wire [3:0] reg_idx = paddr[5:2];
   wire addr_ok = (paddr[1:0] == 2'b00) && (paddr[7:6] == 2'b00);
   wire hit = addr_ok && (reg_idx == sample_ctrl_pkg::idx_a_div ||
      reg_idx == sample_ctrl_pkg::idx_b_div || reg_idx == sample_ctrl_pkg::idx_trim ||
      reg_idx == sample_ctrl_pkg::idx_gain || reg_idx == sample_ctrl_pkg::idx_input ||
      reg_idx == sample_ctrl_pkg::idx_mode || reg_idx == sample_ctrl_pkg::idx_ctrl_word ||
      reg_idx == sample_ctrl_pkg::idx_status);
   // one wait state so that read data can leave a flip-flop
   wire access = psel && penable && !pready;
   wire wr_en = psel && penable && pready && pwrite && !pslverr;
   wire wr_a = wr_en && reg_idx == sample_ctrl_pkg::idx_a_div;
   wire wr_b = wr_en && reg_idx == sample_ctrl_pkg::idx_b_div;
   wire wr_trim = wr_en && reg_idx == sample_ctrl_pkg::idx_trim;
   wire wr_gain = wr_en && reg_idx == sample_ctrl_pkg::idx_gain;
   wire wr_input = wr_en && reg_idx == sample_ctrl_pkg::idx_input;
   wire wr_mode = wr_en && reg_idx == sample_ctrl_pkg::idx_mode;
   wire wr_cw = wr_en && reg_idx == sample_ctrl_pkg::idx_ctrl_word;

   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (reg_idx)
         sample_ctrl_pkg::idx_a_div: rd_mux = 32'(a_div);
         sample_ctrl_pkg::idx_b_div: rd_mux = 32'(b_div);
         sample_ctrl_pkg::idx_trim: rd_mux = 32'(trim);
         sample_ctrl_pkg::idx_gain: rd_mux = 32'(gain_reg);
         sample_ctrl_pkg::idx_input: rd_mux = 32'(input_reg);
         sample_ctrl_pkg::idx_mode: rd_mux = 32'(mode_reg);
         sample_ctrl_pkg::idx_ctrl_word: rd_mux = 32'(ctrl_word);
         sample_ctrl_pkg::idx_status: rd_mux = 32'(status);
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= access;
         pslverr <= access && !hit;
         if (access) begin
            prdata <= (hit && !pwrite) ? rd_mux : 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_div <= div_width'(sample_ctrl_pkg::a_div_reset);
         b_div <= div_width'(sample_ctrl_pkg::b_div_reset);
         trim <= sample_ctrl_pkg::trim_reset;
         gain_reg <= sample_ctrl_pkg::gain_reset;
         input_reg <= sample_ctrl_pkg::input_reset;
         mode_reg <= sample_ctrl_pkg::mode_reset;
      end else begin
         if (wr_a) a_div <= pwdata[div_width-1:0];
         if (wr_b) b_div <= pwdata[div_width-1:0];
         if (wr_trim) trim <= pwdata[7:0];
         if (wr_gain) gain_reg <= pwdata[7:0];
         if (wr_input) input_reg <= pwdata[7:0];
         if (wr_mode) mode_reg <= pwdata[7:0];
      end
   end

   wire free_run = mode_reg[sample_ctrl_pkg::mode_free_run];
   wire sixteen = mode_reg[sample_ctrl_pkg::mode_sixteen];
   wire force_sec = mode_reg[sample_ctrl_pkg::mode_force_sec];

   // =========================================================
   // sampling period counters
   // =========================================================
   logic [div_width+1:0] a_cnt;
   logic [div_width+1:0] b_cnt;
   logic waiting;

   wire a_end = (a_cnt == (div_width + 2)'(1));
   wire [div_width+1:0] b_last = (div_width + 2)'(sample_ctrl_pkg::period_mult) *
      (div_width + 2)'(b_div) - (div_width + 2)'(1);
   // a counter halted in slave timing restarts at once when free run is chosen
   wire period_end = waiting ? free_run : (a_end && (b_cnt >= b_last));
   // free run restarts on its own count, otherwise the host frame sync times it
   wire frame_evt = free_run ? period_end : fs_fall;

   // one-shot request word; a write in the same cycle as the frame event is kept
   wire [1:0] sw_bits = ctrl_word[sample_ctrl_pkg::cw_is_secondary] ?
      ctrl_word[sample_ctrl_pkg::cw_secondary_lsb +: 2] :
      (sixteen ? sample_ctrl_pkg::ctrl_none : ctrl_word[sample_ctrl_pkg::cw_primary_lsb +: 2]);
   wire [2:0] req = decode_req(sw_bits, hw_s2, ctrl_word[sample_ctrl_pkg::cw_is_secondary]);
   wire next_sec = req[2] || sixteen || force_sec;
   wire [div_width+1:0] load_first = first_len(a_div, trim, req[0], req[1]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_word <= 5'h00;
      end else if (wr_cw) begin
         ctrl_word <= pwdata[4:0];
      end else if (frame_evt) begin
         ctrl_word <= 5'h00;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_cnt <= (div_width + 2)'(1);
         b_cnt <= '0;
         waiting <= 1'b0;
      end else if (frame_evt) begin
         a_cnt <= load_first;
         b_cnt <= '0;
         waiting <= 1'b0;
      end else if (period_end) begin
         // slave timing stops and waits for the next external frame sync
         waiting <= 1'b1;
      end else if (a_end && !waiting) begin
         a_cnt <= (div_width + 2)'(a_div);
         b_cnt <= b_cnt + (div_width + 2)'(1);
      end else if (!waiting) begin
         a_cnt <= a_cnt - (div_width + 2)'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_start <= 1'b0;
         filter_clock <= 1'b0;
         secondary_request <= 1'b0;
         adjust_earlier <= 1'b0;
         adjust_later <= 1'b0;
      end else begin
         frame_start <= frame_evt;
         if (frame_evt) begin
            filter_clock <= 1'b0;
         end else if (a_end && !waiting) begin
            filter_clock <= !filter_clock;
         end
         if (frame_evt) begin
            secondary_request <= next_sec;
            adjust_earlier <= req[1];
            adjust_later <= req[0];
         end
      end
   end

   // =========================================================
   // result latch versus serial transfer
   // =========================================================
   logic xfer_active;
   logic [4:0] bit_cnt;
   logic latch_pend;

   wire xfer_start = free_run && fs_fall;
   wire xfer_done = xfer_active && sc_rise && (bit_cnt == sample_ctrl_pkg::shift_bits - 5'h01);
   // the load collides with a transfer under way or starting now
   wire load_blocked = xfer_active || xfer_start;
   wire do_latch = (period_end && free_run && !load_blocked) || (latch_pend && xfer_done);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xfer_active <= 1'b0;
         bit_cnt <= 5'h00;
         latch_pend <= 1'b0;
         result_word <= 16'h0000;
         result_valid <= 1'b0;
      end else begin
         if (xfer_start) begin
            xfer_active <= 1'b1;
            bit_cnt <= 5'h00;
         end else if (xfer_done) begin
            xfer_active <= 1'b0;
            bit_cnt <= 5'h00;
         end else if (xfer_active && sc_rise) begin
            bit_cnt <= bit_cnt + 5'h01;
         end
         if (period_end && free_run && load_blocked) begin
            latch_pend <= 1'b1;
         end else if (do_latch) begin
            latch_pend <= 1'b0;
         end
         if (do_latch || (!free_run && frame_evt)) begin
            result_word <= adc_result;
         end
         result_valid <= do_latch || (!free_run && frame_evt);
      end
   end

   // =========================================================
   // analog routing selections and status
   // =========================================================
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         loopback_en <= 1'b0;
         summing_en <= 1'b0;
         input_gain <= 2'b00;
      end else begin
         loopback_en <= (input_reg[1:0] == sample_ctrl_pkg::sel_loopback);
         summing_en <= (input_reg[1:0] == sample_ctrl_pkg::sel_summing);
         input_gain <= gain_reg[sample_ctrl_pkg::gain_lsb +: 2];
      end
   end

   // the compensation filter stays in path; software corrects other B values
   always_comb begin
      status = 6'h00;
      status[sample_ctrl_pkg::st_sec_req] = secondary_request;
      status[sample_ctrl_pkg::st_earlier] = adjust_earlier;
      status[sample_ctrl_pkg::st_later] = adjust_later;
      status[sample_ctrl_pkg::st_comp_err] =
         (b_div != div_width'(sample_ctrl_pkg::comp_tuned_b));
      status[sample_ctrl_pkg::st_latch_pend] = latch_pend;
      status[sample_ctrl_pkg::st_xfer] = xfer_active;
   end

endmodule : sample_period_ctrl

// *** tb/host_port.sv ***
module host_port (
   input wire logic pclk,
   output logic frame_sync_n,
   output logic shift_clock
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      frame_sync_n = 1'b1;
      shift_clock = 1'b0;
   end
   // =========================================================
   // one 16-bit frame; shift clock stands still low outside it
   // =========================================================
   // caller starts this right after a frame pulse, inside half a filter clock
   task send_frame();
      @(posedge pclk);
      frame_sync_n <= 1'b0;
      for (int i = 0; i < 16; i++) begin
         repeat (2) @(posedge pclk);
         shift_clock <= 1'b1;
         repeat (2) @(posedge pclk);
         shift_clock <= 1'b0;
         frame_sync_n <= 1'b1;
      end
   endtask : send_frame
endmodule : host_port

// *** tb/sample_ctrl_checker.sv ***
module sample_ctrl_checker (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic frame_start,
   input wire logic secondary_request,
   input wire logic adjust_earlier,
   input wire logic adjust_later,
   input wire logic loopback_en,
   input wire logic summing_en,
   input wire logic result_valid
);
   // =========================================================
   // sequences
   // =========================================================
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence setup_phase;
      psel && !penable;
   endsequence
   sequence access_phase;
      psel && penable;
   endsequence

   // =========================================================
   // properties
   // =========================================================
   a_apb_answer: assert property (setup_phase ##1 access_phase |=> pready)
      else $error("pready not one cycle after access");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("error response malformed");
   a_start_pulse: assert property (frame_start |=> !frame_start)
      else $error("frame start not a pulse");
   // a request holds for exactly one period, so it only moves at a frame event
   a_adjust_hold: assert property ($changed(adjust_later) || $changed(adjust_earlier) |-> frame_start)
      else $error("adjust changed between frames");
   a_adjust_excl: assert property (!(adjust_earlier && adjust_later))
      else $error("both adjust directions");
   a_sec_hold: assert property ($changed(secondary_request) |-> frame_start)
      else $error("secondary request changed between frames");
   a_select_excl: assert property (!(loopback_en && summing_en))
      else $error("loopback and summing together");
   a_valid_pulse: assert property (result_valid |=> !result_valid)
      else $error("result valid not a pulse");
endmodule : sample_ctrl_checker

bind sample_period_ctrl sample_ctrl_checker u_chk (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .frame_start(frame_start),
   .secondary_request(secondary_request),
   .adjust_earlier(adjust_earlier),
   .adjust_later(adjust_later),
   .loopback_en(loopback_en),
   .summing_en(summing_en),
   .result_valid(result_valid)
);

// *** tb/tb.sv ***
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, hw_request_hi, hw_request_lo, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, frame_start, filter_clock, secondary_request;
   logic adjust_earlier, adjust_later, loopback_en, summing_en, result_valid;
   logic [1:0] input_gain;
   logic [15:0] adc_result, result_word;
   wire frame_sync_n, shift_clock;
   int miscompares, check_count, frames, cnt, last_per, rv_count, sc_rises;
   // mode, trim, control word, pins<<6, flags earlier/later/secondary
   logic [31:0] cases [12] = '{32'h2003_0102, 32'h2003_0204, 32'h20fd_0102,
      32'h20fd_0204, 32'h2003_0042, 32'h2003_0182, 32'h2003_1804, 32'h2003_1c42,
      32'h2003_00c1, 32'h2803_0101, 32'h2403_0103, 32'h2003_0000};

   sample_period_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .hw_request_hi(hw_request_hi), .hw_request_lo(hw_request_lo),
      .frame_sync_n(frame_sync_n), .shift_clock(shift_clock), .adc_result(adc_result),
      .frame_start(frame_start), .filter_clock(filter_clock),
      .secondary_request(secondary_request), .adjust_earlier(adjust_earlier),
      .adjust_later(adjust_later), .loopback_en(loopback_en), .summing_en(summing_en),
      .input_gain(input_gain), .result_word(result_word), .result_valid(result_valid));
   host_port host (.pclk(pclk), .frame_sync_n(frame_sync_n), .shift_clock(shift_clock));

   // =========================================================
   // clock, monitors, shared tasks
   // =========================================================
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cnt++;
      if (frame_start === 1'b1) begin
         last_per = cnt;
         cnt = 0;
         frames++;
      end
      if (result_valid === 1'b1) rv_count++;
   end
   always @(posedge shift_clock) sc_rises++;

   task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: %s", $time, what);
      end
   endtask : check
   task apb(input logic w, input logic [3:0] idx, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // frame counter is read on the falling edge to stay clear of the monitor
   task wait_frames(input int n);
      int t;
      t = frames + n;
      for (int i = 0; i < 400 && frames < t; i++) @(negedge pclk);
      check(32'(frames >= t), 32'h0000_0001, "frame missing");
   endtask : wait_frames

   // =========================================================
   // scenarios
   // =========================================================
   task test_reset();
      logic [3:0] idx [6] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'hf};
      logic [31:0] exp [6] = '{32'h0000_0012, 32'h0000_000f, 32'h0000_0000,
         32'h0000_0001, 32'h0000_0000, 32'h0000_0000};
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, idx[i], 32'h0000_0000);
         check(rd, exp[i], "reset read");
         check(32'(er), 32'(i == 5), "error response");
      end
      $display("reset test done");
   endtask : test_reset
   task test_ext_sync();
      int f0;
      f0 = frames;
      fork
         host.send_frame();
      join_none
      repeat (10) @(negedge pclk);
      check(32'(frames - f0), 32'h0000_0001, "frame from sync fall");
      wait fork;
      $display("external sync test done");
   endtask : test_ext_sync
   task test_free_run();
      apb(1'b1, sample_ctrl_pkg::idx_a_div, 32'h0000_0004);
      apb(1'b0, sample_ctrl_pkg::idx_status, 32'h0000_0000);
      check(32'(rd[sample_ctrl_pkg::st_comp_err]), 32'h0000_0000, "tuned B");
      apb(1'b1, sample_ctrl_pkg::idx_b_div, 32'h0000_0003);
      apb(1'b0, sample_ctrl_pkg::idx_status, 32'h0000_0000);
      check(32'(rd[sample_ctrl_pkg::st_comp_err]), 32'h0000_0001, "untuned B");
      apb(1'b1, sample_ctrl_pkg::idx_mode, 32'h0000_0020);
      wait_frames(3);
      check(32'(last_per), 32'd24, "nominal period");
      check(32'(filter_clock), 32'h0000_0000, "filter clock at frame");
      repeat (3) @(negedge pclk);
      check(32'(filter_clock), 32'h0000_0001, "filter clock after A");
      $display("free run test done");
   endtask : test_free_run
   task test_adjust();
      int exp;
      for (int i = 0; i < 12; i++) begin
         wait_frames(1);
         @(posedge pclk);
         {hw_request_hi, hw_request_lo} <= cases[i][7:6];
         apb(1'b1, sample_ctrl_pkg::idx_mode, {24'h00_0000, cases[i][31:24]});
         apb(1'b1, sample_ctrl_pkg::idx_trim, {24'h00_0000, cases[i][23:16]});
         apb(1'b1, sample_ctrl_pkg::idx_ctrl_word, {24'h00_0000, cases[i][15:8]});
         wait_frames(1);
         check(32'(adjust_earlier), 32'(cases[i][2]), "earlier flag");
         check(32'(adjust_later), 32'(cases[i][1]), "later flag");
         check(32'(secondary_request), 32'(cases[i][0]), "secondary");
         @(posedge pclk);
         {hw_request_hi, hw_request_lo} <= 2'b00;
         exp = 24 + (cases[i][1] ? int'($signed(cases[i][23:16])) : 0);
         exp = exp - (cases[i][2] ? int'($signed(cases[i][23:16])) : 0);
         wait_frames(1);
         check(32'(last_per), 32'(exp), "adjusted period");
         wait_frames(1);
         check(32'(last_per), 32'd24, "back to nominal");
      end
      $display("adjust test done");
   endtask : test_adjust
   // a load that lands inside a transfer must wait for the 16th shift clock
   task test_collision();
      int c0, s0;
      wait_frames(1);
      s0 = sc_rises;
      fork
         host.send_frame();
      join_none
      repeat (8) @(negedge pclk);
      c0 = rv_count;
      @(posedge pclk);
      adc_result <= 16'hc3a5;
      wait (sc_rises == s0 + 16);
      @(negedge pclk);
      check(32'(rv_count - c0), 32'h0000_0000, "latch during transfer");
      c0 = rv_count;
      // short window: the next regular load must not be mistaken for the deferred one
      repeat (5) @(negedge pclk);
      check(32'(rv_count > c0), 32'h0000_0001, "deferred latch");
      check({16'h0000, result_word}, 32'h0000_c3a5, "latched word");
      wait fork;
      $display("collision test done");
   endtask : test_collision
   task test_inputs();
      apb(1'b1, sample_ctrl_pkg::idx_input, 32'h0000_0000);
      repeat (2) @(negedge pclk);
      check(32'({loopback_en, summing_en}), 32'h0000_0002, "loopback");
      apb(1'b1, sample_ctrl_pkg::idx_input, 32'h0000_0003);
      apb(1'b1, sample_ctrl_pkg::idx_gain, 32'h0000_000c);
      repeat (2) @(negedge pclk);
      check(32'({loopback_en, summing_en}), 32'h0000_0001, "summing");
      check(32'(input_gain), 32'h0000_0003, "gain field");
      $display("input select test done");
   endtask : test_inputs

   // =========================================================
   // run control
   // =========================================================
   task complete_run();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run
   initial begin
      #400000;
      miscompares++;
      complete_run();
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, hw_request_hi, hw_request_lo} = 5'b00000;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      adc_result = 16'h5a5a;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      test_reset();
      test_ext_sync();
      test_free_run();
      test_adjust();
      test_collision();
      test_inputs();
      complete_run();
   end
endmodule : tb
